/* File: rtl/ocdb_top.v */
// Output channel divider bank: six channel dividers, output group fan-out,
// second loop phase/lock detector and loop bandwidth selection, with an
// Avalon-MM register slave. Source clocks and detector inputs are pins,
// sampled on clk; they must stay below a quarter of the clk rate.
//
// Notes on behaviour
// - Six integer channel dividers, ratio in bits 5..0 of each ratio register.
// - Every divider divides by any integer from 1 to 64.
// - Ratios reset to four; the zero-delay feedback divider resets to one.
// - Six-bit phase field delays the first edge in input half periods.
// - Bit 6 of each group ratio register powers that divider down.
// - Group 0 and zero-delay dividers always use the primary oscillator divider.
// - Groups 1 and 2: phase bit 6 zero primary, one secondary source.
// - Group 3: phase bit 6 zero second loop, one primary source.
// - Group 4 divider is always clocked by the second loop oscillator.
// - Dividers fan out to four, two, two, two and one drivers.
// - Phase detector gives separate up and down pulses sized by phase difference.
// - Lock detector evaluates once per phase detector comparison.
// - Second loop flagged locked while sampled phase error stays within one clk cycle; 3.25 ns rounds up to one.
// - Lock typically reported about 420 us after reset release.
// - Bandwidth chosen from feedback value: 4-23, 24-47, 48-255.
// - Feedback divide value may change live without a reset.
// - A divider is held in reset while its sync input is high.
`timescale 1ns/1ns
`include "ocdb_defines.vh"

module ocdb_chdiv
(
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       half_tick,
  input  wire       sync_hold,
  input  wire       power_down,
  input  wire [5:0] ratio,
  input  wire [5:0] phase,
  output reg        div_out_r
);

  reg  [5:0] dly_r;
  reg  [6:0] cnt_r;
  reg        started_r;
  wire [6:0] ratio_val;

  // A zero field stands for 64 so the full 1..64 range fits six bits.
  assign ratio_val = (ratio == 6'h00) ? 7'h40 : {1'b0, ratio};

  always @(posedge clk)
  begin
    if (sys_rst || sync_hold || power_down)
    begin
      div_out_r <= 1'b0;
      cnt_r     <= 7'h00;
      dly_r     <= phase;
      started_r <= 1'b0;
    end
    else if (half_tick)
    begin
      if (dly_r != 6'h00)
      begin
        dly_r <= dly_r - 6'h01;
      end
      else if (!started_r)
      begin
        started_r <= 1'b1;
        div_out_r <= 1'b1;
        cnt_r     <= 7'h01;
      end
      else if (cnt_r >= ratio_val)
      begin
        // Toggling every ratio half periods gives an even duty cycle for odd ratios too.
        div_out_r <= ~div_out_r;
        cnt_r     <= 7'h01;
      end
      else
      begin
        cnt_r <= cnt_r + 7'h01;
      end
    end
  end

endmodule // ocdb_chdiv

module ocdb_top
#(
  parameter integer LOCK_QUAL_CYC = `OCDB_LOCK_TIME_US * `OCDB_CLK_MHZ
)
(
  input  wire        clk,
  input  wire        sys_rst,
  input  wire [9:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire        primary_osc_clk,
  input  wire        secondary_osc_clk,
  input  wire        second_loop_osc_clk,
  input  wire        second_loop_ref_div,
  input  wire        second_loop_fb_div,
  output reg  [3:0]  group0_drv,
  output reg  [1:0]  group1_drv,
  output reg  [1:0]  group2_drv,
  output reg  [1:0]  group3_drv,
  output reg         group4_drv,
  output reg         zero_delay_fb_out,
  output reg         pfd_up,
  output reg         pfd_dn,
  output reg         second_loop_locked,
  output reg  [1:0]  loop_bw_sel,
  output reg  [7:0]  fb_div_value
);

  localparam integer LOCK_ERR_RAW = `OCDB_LOCK_ERR_PS / `OCDB_CLK_PERIOD_PS;
  localparam integer LOCK_ERR_CYC = (LOCK_ERR_RAW < 1) ? 1 : LOCK_ERR_RAW;
  localparam [15:0]  LOCK_ERR_W   = LOCK_ERR_CYC[15:0];
  localparam [31:0]  LOCK_QUAL_W  = LOCK_QUAL_CYC;

  // Register storage.
  reg [6:0] g0_ratio_r;
  reg [5:0] g0_phase_r;
  reg [6:0] g1_ratio_r;
  reg [6:0] g1_phase_r;
  reg [6:0] g2_ratio_r;
  reg [6:0] g2_phase_r;
  reg [6:0] g3_ratio_r;
  reg [6:0] g3_phase_r;
  reg [6:0] g4_ratio_r;
  reg [5:0] g4_phase_r;
  reg [5:0] zd_ratio_r;
  reg [5:0] zd_phase_r;
  reg [5:0] sync_r;
  reg [7:0] rdata_nxt;

  // Bus handshake.
  wire bus_req;
  wire bus_wr;
  assign bus_req = avs_read | avs_write;
  assign bus_wr  = avs_write & ~avs_waitrequest & avs_byteenable[0];

  // Source clock and detector input synchronisers; stage 2 feeds stage 3 for edges.
  reg [2:0] prim_s_r;
  reg [2:0] sec_s_r;
  reg [2:0] l2_s_r;
  reg [2:0] ref_s_r;
  reg [2:0] fb_s_r;

  // The synchronisers are not reset: clearing them while a pin is high would fake an edge at reset release.
  always @(posedge clk)
  begin
    prim_s_r <= {prim_s_r[1:0], primary_osc_clk};
    sec_s_r  <= {sec_s_r[1:0], secondary_osc_clk};
    l2_s_r   <= {l2_s_r[1:0], second_loop_osc_clk};
    ref_s_r  <= {ref_s_r[1:0], second_loop_ref_div};
    fb_s_r   <= {fb_s_r[1:0], second_loop_fb_div};
  end

  // Both edges of a source count as one half period.
  wire prim_half;
  wire sec_half;
  wire l2_half;
  wire ref_rise;
  wire fb_rise;
  assign prim_half = prim_s_r[2] ^ prim_s_r[1];
  assign sec_half  = sec_s_r[2] ^ sec_s_r[1];
  assign l2_half   = l2_s_r[2] ^ l2_s_r[1];
  assign ref_rise  = ref_s_r[1] & ~ref_s_r[2];
  assign fb_rise   = fb_s_r[1] & ~fb_s_r[2];

  // Source selection per divider.
  wire g1_tick;
  wire g2_tick;
  wire g3_tick;
  assign g1_tick = g1_phase_r[`OCDB_SRC_BIT] ? sec_half : prim_half;
  assign g2_tick = g2_phase_r[`OCDB_SRC_BIT] ? sec_half : prim_half;
  assign g3_tick = g3_phase_r[`OCDB_SRC_BIT] ? prim_half : l2_half;

  wire [5:0] div_q;

  ocdb_chdiv u_div_g0
  (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .half_tick  (prim_half),
    .sync_hold  (sync_r[0]),
    .power_down (g0_ratio_r[`OCDB_PD_BIT]),
    .ratio      (g0_ratio_r[`OCDB_RATIO_MSB:0]),
    .phase      (g0_phase_r),
    .div_out_r  (div_q[0])
  );

  ocdb_chdiv u_div_g1
  (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .half_tick  (g1_tick),
    .sync_hold  (sync_r[1]),
    .power_down (g1_ratio_r[`OCDB_PD_BIT]),
    .ratio      (g1_ratio_r[`OCDB_RATIO_MSB:0]),
    .phase      (g1_phase_r[`OCDB_PHASE_MSB:0]),
    .div_out_r  (div_q[1])
  );

  ocdb_chdiv u_div_g2
  (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .half_tick  (g2_tick),
    .sync_hold  (sync_r[2]),
    .power_down (g2_ratio_r[`OCDB_PD_BIT]),
    .ratio      (g2_ratio_r[`OCDB_RATIO_MSB:0]),
    .phase      (g2_phase_r[`OCDB_PHASE_MSB:0]),
    .div_out_r  (div_q[2])
  );

  ocdb_chdiv u_div_g3
  (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .half_tick  (g3_tick),
    .sync_hold  (sync_r[3]),
    .power_down (g3_ratio_r[`OCDB_PD_BIT]),
    .ratio      (g3_ratio_r[`OCDB_RATIO_MSB:0]),
    .phase      (g3_phase_r[`OCDB_PHASE_MSB:0]),
    .div_out_r  (div_q[3])
  );

  ocdb_chdiv u_div_g4
  (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .half_tick  (l2_half),
    .sync_hold  (sync_r[4]),
    .power_down (g4_ratio_r[`OCDB_PD_BIT]),
    .ratio      (g4_ratio_r[`OCDB_RATIO_MSB:0]),
    .phase      (g4_phase_r),
    .div_out_r  (div_q[4])
  );

  // The zero-delay divider has no power-down control.
  ocdb_chdiv u_div_zd
  (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .half_tick  (prim_half),
    .sync_hold  (sync_r[5]),
    .power_down (1'b0),
    .ratio      (zd_ratio_r),
    .phase      (zd_phase_r),
    .div_out_r  (div_q[5])
  );

  // Driver fan-out, one register stage so every pin comes from a flop.
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      group0_drv        <= 4'h0;
      group1_drv        <= 2'h0;
      group2_drv        <= 2'h0;
      group3_drv        <= 2'h0;
      group4_drv        <= 1'b0;
      zero_delay_fb_out <= 1'b0;
    end
    else
    begin
      group0_drv        <= {4{div_q[0]}};
      group1_drv        <= {2{div_q[1]}};
      group2_drv        <= {2{div_q[2]}};
      group3_drv        <= {2{div_q[3]}};
      group4_drv        <= div_q[4];
      zero_delay_fb_out <= div_q[5];
    end
  end

  // Second loop phase detector and lock detector.
  reg [15:0] err_cnt_r;
  reg [31:0] qual_cnt_r;
  reg        cmp_done;
  reg        cmp_good;

  always @*
  begin
    cmp_done = 1'b0;
    cmp_good = 1'b0;
    if (ref_rise && fb_rise && !pfd_up && !pfd_dn)
    begin
      cmp_done = 1'b1;
      cmp_good = 1'b1;
    end
    else if ((pfd_up && fb_rise) || (pfd_dn && ref_rise))
    begin
      cmp_done = 1'b1;
      cmp_good = (err_cnt_r < LOCK_ERR_W);
    end
  end

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      pfd_up             <= 1'b0;
      pfd_dn             <= 1'b0;
      err_cnt_r          <= 16'h0000;
      qual_cnt_r         <= 32'h00000000;
      second_loop_locked <= 1'b0;
    end
    else
    begin
      // Up runs from a reference edge to the next feedback edge, down the reverse.
      if (cmp_done)
      begin
        pfd_up    <= 1'b0;
        pfd_dn    <= 1'b0;
        err_cnt_r <= 16'h0000;
      end
      else if (!pfd_up && !pfd_dn && ref_rise)
      begin
        pfd_up <= 1'b1;
      end
      else if (!pfd_up && !pfd_dn && fb_rise)
      begin
        pfd_dn <= 1'b1;
      end
      else if ((pfd_up || pfd_dn) && (err_cnt_r != 16'hFFFF))
      begin
        err_cnt_r <= err_cnt_r + 16'h0001;
      end

      // Lock is earned by a qualification time of clean comparisons and lost on one bad one.
      if (cmp_done && !cmp_good)
      begin
        qual_cnt_r         <= 32'h00000000;
        second_loop_locked <= 1'b0;
      end
      else if (qual_cnt_r >= LOCK_QUAL_W)
      begin
        second_loop_locked <= 1'b1;
      end
      else if (cmp_good || (qual_cnt_r != 32'h00000000))
      begin
        qual_cnt_r <= qual_cnt_r + 32'h00000001;
      end
    end
  end

  // Register file write side and live feedback value outputs.
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      g0_ratio_r   <= `OCDB_RATIO_RST;
      g1_ratio_r   <= `OCDB_RATIO_RST;
      g2_ratio_r   <= `OCDB_RATIO_RST;
      g3_ratio_r   <= `OCDB_RATIO_RST;
      g4_ratio_r   <= `OCDB_RATIO_RST;
      zd_ratio_r   <= `OCDB_ZD_RATIO_RST;
      g0_phase_r   <= 6'h00;
      g1_phase_r   <= `OCDB_PHASE_RST;
      g2_phase_r   <= `OCDB_PHASE_RST;
      g3_phase_r   <= `OCDB_PHASE_RST;
      g4_phase_r   <= 6'h00;
      zd_phase_r   <= 6'h00;
      sync_r       <= `OCDB_SYNC_RST;
      fb_div_value <= `OCDB_FB_DIV_RST;
    end
    else if (bus_wr)
    begin
      case (avs_address)
        `OCDB_IDX_ZD_CTRL      : zd_ratio_r   <= avs_writedata[5:0];
        `OCDB_IDX_G0_RATIO     : g0_ratio_r   <= avs_writedata[6:0];
        `OCDB_IDX_G0_PHASE     : g0_phase_r   <= avs_writedata[5:0];
        `OCDB_IDX_G1_RATIO     : g1_ratio_r   <= avs_writedata[6:0];
        `OCDB_IDX_G1_PHASE_SRC : g1_phase_r   <= avs_writedata[6:0];
        `OCDB_IDX_G2_RATIO     : g2_ratio_r   <= avs_writedata[6:0];
        `OCDB_IDX_G2_PHASE_SRC : g2_phase_r   <= avs_writedata[6:0];
        `OCDB_IDX_G3_RATIO     : g3_ratio_r   <= avs_writedata[6:0];
        `OCDB_IDX_G3_PHASE_SRC : g3_phase_r   <= avs_writedata[6:0];
        `OCDB_IDX_G4_RATIO     : g4_ratio_r   <= avs_writedata[6:0];
        `OCDB_IDX_G4_PHASE     : g4_phase_r   <= avs_writedata[5:0];
        `OCDB_IDX_SYNC_CTRL    : sync_r       <= avs_writedata[5:0];
        `OCDB_IDX_FB_DIV       : fb_div_value <= avs_writedata[7:0];
        `OCDB_IDX_ZD_PHASE     : zd_phase_r   <= avs_writedata[5:0];
        default                : sync_r       <= sync_r;
      endcase
    end
  end

  // Bandwidth follows the feedback value without disturbing the lock state.
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      loop_bw_sel <= `OCDB_BW_MID;
    end
    else if (fb_div_value >= `OCDB_BW_LOW_MIN)
    begin
      loop_bw_sel <= `OCDB_BW_LOW;
    end
    else if (fb_div_value >= `OCDB_BW_MID_MIN)
    begin
      loop_bw_sel <= `OCDB_BW_MID;
    end
    else
    begin
      loop_bw_sel <= `OCDB_BW_HIGH;
    end
  end

  // Read mux; unmapped indices read as zero.
  always @*
  begin
    case (avs_address)
      `OCDB_IDX_ZD_CTRL      : rdata_nxt = {2'h0, zd_ratio_r};
      `OCDB_IDX_G0_RATIO     : rdata_nxt = {1'b0, g0_ratio_r};
      `OCDB_IDX_G0_PHASE     : rdata_nxt = {2'h0, g0_phase_r};
      `OCDB_IDX_G1_RATIO     : rdata_nxt = {1'b0, g1_ratio_r};
      `OCDB_IDX_G1_PHASE_SRC : rdata_nxt = {1'b0, g1_phase_r};
      `OCDB_IDX_G2_RATIO     : rdata_nxt = {1'b0, g2_ratio_r};
      `OCDB_IDX_G2_PHASE_SRC : rdata_nxt = {1'b0, g2_phase_r};
      `OCDB_IDX_G3_RATIO     : rdata_nxt = {1'b0, g3_ratio_r};
      `OCDB_IDX_G3_PHASE_SRC : rdata_nxt = {1'b0, g3_phase_r};
      `OCDB_IDX_G4_RATIO     : rdata_nxt = {1'b0, g4_ratio_r};
      `OCDB_IDX_G4_PHASE     : rdata_nxt = {2'h0, g4_phase_r};
      `OCDB_IDX_SYNC_CTRL    : rdata_nxt = {2'h0, sync_r};
      `OCDB_IDX_FB_DIV       : rdata_nxt = fb_div_value;
      `OCDB_IDX_STATUS       : rdata_nxt = {2'h0, div_q[5], pfd_dn, pfd_up, loop_bw_sel, second_loop_locked};
      `OCDB_IDX_ZD_PHASE     : rdata_nxt = {2'h0, zd_phase_r};
      default                : rdata_nxt = 8'h00;
    endcase
  end

  // Every access gets exactly one wait state; waitrequest idles high.
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end
    else if (bus_req && avs_waitrequest)
    begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= {24'h000000, rdata_nxt};
    end
    else
    begin
      avs_waitrequest <= 1'b1;
    end
  end

endmodule // ocdb_top

/* File: rtl/ocdb_defines.vh */
// Constants for the output channel divider bank: register indices, field
// positions, reset values and timing figures.
// Assumes a word-addressed Avalon-MM slave; byte address is four times the index.
`ifndef OCDB_DEFINES_VH
`define OCDB_DEFINES_VH

// Register indices (byte address = 4 * index).
`define OCDB_IDX_ZD_CTRL       10'h110
`define OCDB_IDX_G0_RATIO      10'h140
`define OCDB_IDX_G0_PHASE      10'h141
`define OCDB_IDX_G1_RATIO      10'h146
`define OCDB_IDX_G1_PHASE_SRC  10'h147
`define OCDB_IDX_G2_RATIO      10'h14A
`define OCDB_IDX_G2_PHASE_SRC  10'h14B
`define OCDB_IDX_G3_RATIO      10'h240
`define OCDB_IDX_G3_PHASE_SRC  10'h241
`define OCDB_IDX_G4_RATIO      10'h244
`define OCDB_IDX_G4_PHASE      10'h245
`define OCDB_IDX_SYNC_CTRL     10'h300
`define OCDB_IDX_FB_DIV        10'h301
`define OCDB_IDX_STATUS        10'h302
`define OCDB_IDX_ZD_PHASE      10'h303

// Field positions.
`define OCDB_RATIO_MSB         5
`define OCDB_PHASE_MSB         5
`define OCDB_PD_BIT            6
`define OCDB_SRC_BIT           6

// Reset values.
`define OCDB_RATIO_RST         7'h04
`define OCDB_ZD_RATIO_RST      6'h01
`define OCDB_PHASE_RST         7'h00
`define OCDB_SYNC_RST          6'h00
`define OCDB_FB_DIV_RST        8'h20

// Loop bandwidth ranges of the feedback divide value.
`define OCDB_BW_MID_MIN        8'h18
`define OCDB_BW_LOW_MIN        8'h30
`define OCDB_BW_HIGH           2'h0
`define OCDB_BW_MID            2'h1
`define OCDB_BW_LOW            2'h2

// Timing.
`define OCDB_CLK_PERIOD_PS     10000
`define OCDB_CLK_MHZ           100
`define OCDB_LOCK_ERR_PS       3250
`define OCDB_LOCK_TIME_US      420

`endif

/* File: testbench/ocdb_top_sva.sv */
// Checker for the divider bank top: bus answer, fan-out, bandwidth and lock.
// Assumes it is bound to ocdb_top and sees only that module's ports.
`timescale 1ns/1ns
module ocdb_chk
#(
  parameter integer LOCK_QUAL_CYC = 50
)
(
  input wire        clk,
  input wire        sys_rst,
  input wire        avs_read,
  input wire        avs_waitrequest,
  input wire [31:0] avs_readdata,
  input wire [3:0]  group0_drv,
  input wire [1:0]  group1_drv,
  input wire [1:0]  group2_drv,
  input wire [1:0]  group3_drv,
  input wire        pfd_up,
  input wire        pfd_dn,
  input wire        second_loop_locked,
  input wire [1:0]  loop_bw_sel,
  input wire [7:0]  fb_div_value
);
  // The detector output is registered, so a few cycles of slack are allowed.
  localparam integer QMIN = LOCK_QUAL_CYC - 8;
  reg     up_d_r;
  reg     dn_d_r;
  integer quiet_r;

  // Counts cycles since the last pulse that was too wide to be a good comparison.
  always @(posedge clk)
  begin
    up_d_r <= pfd_up;
    dn_d_r <= pfd_dn;
    if (sys_rst || (pfd_up && up_d_r) || (pfd_dn && dn_d_r))
      quiet_r <= 0;
    else if (quiet_r < 1000000)
      quiet_r <= quiet_r + 1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_wide_up;
    pfd_up [*3] ##1 !pfd_up;
  endsequence
  sequence s_fb_still;
    $stable(fb_div_value) [*2];
  endsequence

  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("waitrequest low for more than one cycle");
  property p_read_ans;
    $rose(avs_read) |=> !avs_waitrequest;
  endproperty
  a_read_ans: assert property (p_read_ans)
    else $error("read not answered in one cycle");
  property p_rd_hi;
    !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000;
  endproperty
  a_rd_hi: assert property (p_rd_hi)
    else $error("upper read data bits set");
  property p_bw;
    s_fb_still |-> loop_bw_sel == (fb_div_value >= 8'h30 ? 2'h2 : (fb_div_value >= 8'h18 ? 2'h1 : 2'h0));
  endproperty
  a_bw: assert property (p_bw)
    else $error("bandwidth select does not match feedback value");
  property p_excl;
    !(pfd_up && pfd_dn);
  endproperty
  a_excl: assert property (p_excl)
    else $error("up and down pulses together");
  property p_g0;
    group0_drv == 4'h0 || group0_drv == 4'hF;
  endproperty
  a_g0: assert property (p_g0)
    else $error("group 0 drivers differ");
  property p_g123;
    group1_drv[0] == group1_drv[1] && group2_drv[0] == group2_drv[1] && group3_drv[0] == group3_drv[1];
  endproperty
  a_g123: assert property (p_g123)
    else $error("paired drivers differ");
  property p_lock_clr;
    s_wide_up |-> ##[0:6] !second_loop_locked;
  endproperty
  a_lock_clr: assert property (p_lock_clr)
    else $error("lock kept after wide phase error");
  property p_lock_qual;
    $rose(second_loop_locked) |-> quiet_r >= QMIN;
  endproperty
  a_lock_qual: assert property (p_lock_qual)
    else $error("lock declared too early");
endmodule // ocdb_chk

bind ocdb_top ocdb_chk #(.LOCK_QUAL_CYC(LOCK_QUAL_CYC)) u_chk
(
  .clk,
  .sys_rst,
  .avs_read,
  .avs_waitrequest,
  .avs_readdata,
  .group0_drv,
  .group1_drv,
  .group2_drv,
  .group3_drv,
  .pfd_up,
  .pfd_dn,
  .second_loop_locked,
  .loop_bw_sel,
  .fb_div_value
);

/* File: testbench/ocdb_top_tb.sv */
// Self-checking bench for the divider bank: registers, ratios, sources,
// phase, power-down, sync hold, bandwidth and lock. Assumes the rtl files.
`timescale 1ns/1ns
module ocdb_top_tb;
  localparam integer QUAL = 50;
  reg          clk;
  reg          sys_rst;
  reg  [9:0]   avs_address;
  reg          avs_read;
  reg          avs_write;
  reg  [31:0]  avs_writedata;
  wire [31:0]  avs_readdata;
  wire         avs_waitrequest;
  reg          p_clk;
  reg          s_clk;
  reg          l_clk;
  reg          ref_div;
  reg          fb_div;
  wire [3:0]   g0;
  wire [1:0]   g1;
  wire [1:0]   g2;
  wire [1:0]   g3;
  wire         g4;
  wire         zd;
  wire         up;
  wire         dn;
  wire         locked;
  wire [1:0]   bw;
  wire [7:0]   fbv;
  wire [5:0]   outs = {zd, g4, g3[0], g2[0], g1[0], g0[0]};
  integer      miscompares;
  integer      n_compared;
  integer      cyc;
  integer      skew;
  logic [31:0] q;
  logic [9:0]  ra [0:10] = '{10'h110, 10'h140, 10'h141, 10'h146, 10'h147, 10'h14A, 10'h14B, 10'h240, 10'h241,
                              10'h244, 10'h245};
  logic [7:0]  rv [0:10] = '{8'h01, 8'h04, 8'h00, 8'h04, 8'h00, 8'h04, 8'h00, 8'h04, 8'h00, 8'h04, 8'h00};
  logic [7:0]  wv [0:10] = '{8'h15, 8'h55, 8'h15, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h15};
  integer      ep [0:11] = '{16, 16, 16, 20, 20, 16, 16, 24, 24, 16, 20, 16};

  ocdb_top #(.LOCK_QUAL_CYC(QUAL)) u_dut
  (
    .clk,
    .sys_rst,
    .avs_address,
    .avs_read,
    .avs_write,
    .avs_writedata,
    .avs_byteenable      (4'hF),
    .avs_readdata,
    .avs_waitrequest,
    .primary_osc_clk     (p_clk),
    .secondary_osc_clk   (s_clk),
    .second_loop_osc_clk (l_clk),
    .second_loop_ref_div (ref_div),
    .second_loop_fb_div  (fb_div),
    .group0_drv          (g0),
    .group1_drv          (g1),
    .group2_drv          (g2),
    .group3_drv          (g3),
    .group4_drv          (g4),
    .zero_delay_fb_out   (zd),
    .pfd_up              (up),
    .pfd_dn              (dn),
    .second_loop_locked  (locked),
    .loop_bw_sel         (bw),
    .fb_div_value        (fbv)
  );

  always #5 clk = ~clk;

  // Source clocks keep each half period at four clk cycles or more.
  always @(posedge clk)
  begin
    cyc     <= cyc + 1;
    p_clk   <= (cyc % 8) < 4;
    s_clk   <= (cyc % 12) < 6;
    l_clk   <= (cyc % 10) < 5;
    ref_div <= (cyc % 40) < 20;
    fb_div  <= ((cyc - skew + 400) % 40) < 20;
    if (cyc == 20000)
    begin
      miscompares = miscompares + 1;
      print_verdict;
    end
  end

  task print_verdict;
  begin
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
  begin
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  end
  endtask

  task bus(input logic wr_en, input logic [9:0] a, input logic [7:0] d);
  begin
    @(posedge clk);
    avs_read      <= !wr_en;
    avs_write     <= wr_en;
    avs_address   <= a;
    avs_writedata <= {24'h000000, d};
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  end
  endtask

  task wr(input logic [9:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task do_reset;
  begin
    sys_rst <= 1'b1;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
  end
  endtask

  task resync;
  begin
    wr(10'h300, 8'h3F);
    wr(10'h300, 8'h00);
  end
  endtask

  task wait_rise(input integer i);
  begin
    @(posedge clk);
    while (outs[i] !== 1'b0)
      @(posedge clk);
    while (outs[i] !== 1'b1)
      @(posedge clk);
  end
  endtask

  task period(input integer i, output integer p);
    integer t0;
  begin
    wait_rise(i);
    t0 = cyc;
    wait_rise(i);
    p = cyc - t0;
  end
  endtask

  task highs(input integer i, output integer n);
  begin
    n = 0;
    // The divider and the driver stage need a few cycles to show a new control value.
    repeat (4) @(posedge clk);
    repeat (64)
    begin
      @(posedge clk);
      n = n + outs[i];
    end
  end
  endtask

  task t_regs;
    integer i;
    integer p;
  begin
    period(0, p);
    chk(p, 32, "default group0 period");
    period(5, p);
    chk(p, 8, "default zero-delay period");
    chk({24'h000000, fbv}, 32'h00000020, "feedback reset");
    chk({30'h0, bw}, 32'h00000001, "bandwidth reset");
    for (i = 0; i < 11; i = i + 1)
    begin
      bus(1'b0, ra[i], 8'h00);
      chk(q, {24'h000000, rv[i]}, "register reset");
      wr(ra[i], wv[i]);
      bus(1'b0, ra[i], 8'h00);
      chk(q, {24'h000000, wv[i]}, "register readback");
    end
    wr(10'h3FF, 8'hAA);
    bus(1'b0, 10'h3FF, 8'h00);
    chk(q, 32'h00000000, "unmapped read");
    $display("test regs done");
  end
  endtask

  task t_ratio;
    integer p;
  begin
    wr(10'h140, 8'h01);
    resync;
    period(0, p);
    chk(p, 8, "ratio one period");
    wr(10'h140, 8'h00);
    resync;
    period(0, p);
    chk(p, 512, "ratio sixty-four period");
    $display("test ratio done");
  end
  endtask

  task t_sources;
    integer i;
    integer s;
    integer p;
  begin
    for (i = 0; i < 11; i = i + 1)
      if (rv[i] != 8'h00)
        wr(ra[i], 8'h02);
    for (s = 0; s < 2; s = s + 1)
    begin
      wr(10'h147, {1'b0, s[0], 6'h00});
      wr(10'h14B, {1'b0, s[0], 6'h00});
      wr(10'h241, {1'b0, s[0], 6'h00});
      resync;
      for (i = 0; i < 6; i = i + 1)
      begin
        period(i, p);
        chk(p, ep[s * 6 + i], "source period");
      end
    end
    $display("test sources done");
  end
  endtask

  task t_phase;
    integer k;
    integer t1;
    integer t2;
  begin
    wr(10'h146, 8'h08);
    wr(10'h14A, 8'h08);
    wr(10'h147, 8'h00);
    for (k = 1; k < 64; k = k + 62)
    begin
      wr(10'h14B, k[7:0]);
      resync;
      t1 = 0;
      t2 = 0;
      while (t1 == 0 || t2 == 0)
      begin
        @(posedge clk);
        if (t1 == 0 && outs[1] === 1'b1)
          t1 = cyc;
        if (t2 == 0 && outs[2] === 1'b1)
          t2 = cyc;
      end
      chk(t2 - t1, 4 * k, "phase delay");
    end
    $display("test phase done");
  end
  endtask

  task t_hold;
    integer n;
  begin
    wr(10'h240, 8'h42);
    highs(3, n);
    chk(n, 0, "powered-down group3");
    wr(10'h240, 8'h02);
    resync;
    period(3, n);
    chk(n, 16, "group3 after power-up");
    wr(10'h300, 8'h10);
    highs(4, n);
    chk(n, 0, "held group4");
    wr(10'h300, 8'h00);
    period(4, n);
    chk(n, 20, "group4 after hold");
    $display("test hold done");
  end
  endtask

  task t_bw;
    integer i;
    logic [7:0] v [0:5];
    logic [1:0] e [0:5];
  begin
    v = '{8'h04, 8'h17, 8'h18, 8'h2F, 8'h30, 8'hFF};
    e = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
    for (i = 0; i < 6; i = i + 1)
    begin
      wr(10'h301, v[i]);
      repeat (3) @(posedge clk);
      chk({30'h0, bw}, {30'h0, e[i]}, "bandwidth select");
      chk({24'h000000, fbv}, {24'h000000, v[i]}, "live feedback value");
      bus(1'b0, 10'h302, 8'h00);
      chk({30'h0, q[2:1]}, {30'h0, e[i]}, "status bandwidth");
    end
    $display("test bandwidth done");
  end
  endtask

  task t_lock;
    integer k;
    integer nu;
    integer nd;
  begin
    skew = 0;
    for (k = 0; k < 3000 && locked !== 1'b1; k = k + 1)
      @(posedge clk);
    chk(locked, 1, "lock with aligned inputs");
    for (k = 3; k > -4; k = k - 6)
    begin
      skew = k;
      // Let the pulse left over from the old skew finish before counting.
      repeat (80) @(posedge clk);
      nu = 0;
      nd = 0;
      repeat (200)
      begin
        @(posedge clk);
        nu = nu + up;
        nd = nd + dn;
      end
      chk(locked, 0, "lock lost on phase error");
      chk({nu != 0, nd != 0}, (k > 0) ? 2 : 1, "up or down pulses");
    end
    skew = 0;
    $display("test lock done");
  end
  endtask

  initial
  begin
    clk            = 1'b0;
    sys_rst        = 1'b1;
    avs_address    = 10'h000;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h00000000;
    p_clk          = 1'b0;
    s_clk          = 1'b0;
    l_clk          = 1'b0;
    ref_div        = 1'b0;
    fb_div         = 1'b0;
    miscompares    = 0;
    n_compared     = 0;
    cyc            = 0;
    skew           = 0;
    do_reset;
    t_regs;
    do_reset;
    t_ratio;
    t_sources;
    t_phase;
    t_hold;
    t_bw;
    t_lock;
    print_verdict;
  end
endmodule // ocdb_top_tb
